// >>> src/cycle_timing_pkg.sv
package cycle_timing_pkg;

	// ------------------------------------------------------------
	// Timing limits
	// ------------------------------------------------------------
	localparam int unsigned MAX_CYCLES = 8; // Longest instruction, in clocks
	localparam int unsigned CORE_MAX_MHZ = 25; // Highest core clock the timing is built for
	localparam int unsigned PEAK_MIPS = 25; // One instruction per clock at full rate
	localparam int unsigned SYS_CLK_MHZ = 250; // Clock of this implementation
	localparam int unsigned INSTR_COUNT = 109; // Distinct instructions covered by the decoder
	localparam int unsigned CNT_W = 4; // Width of cycle counters

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [CNT_W-1:0] REM_RST = 4'h0; // No cycles outstanding
	localparam logic [15:0] ADDR_RST = 16'h0000; // Memory address after reset

	// ------------------------------------------------------------
	// Opcodes the sequencer treats by name
	// ------------------------------------------------------------
	localparam logic [7:0] OP_JMP_ACC_ZERO = 8'h60; // Jump if accumulator zero
	localparam logic [7:0] OP_XMOVE_RD_DATA_POINTER_REG = 8'he0; // Ext data move, read via data pointer
	localparam logic [7:0] OP_XMOVE_WR_DATA_POINTER_REG = 8'hf0; // Ext data move, write via data pointer
	localparam logic [7:0] OP_UNDEFINED = 8'ha5; // Only code point with no instruction

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MEM_NONE = 2'b00, // No memory move
		MEM_XRI = 2'b01, // Ext data move, index register address
		MEM_XDPTR = 2'b10, // Ext data move, data pointer address
		MEM_CODE = 2'b11 // Code byte move from program flash
	} mem_kind_t;

	typedef enum logic [1:0] {
		DBG_RUN = 2'b00, // Free running
		DBG_HALT = 2'b01, // Stopped by the debug host
		DBG_STEP = 2'b10 // One instruction allowed, then stop
	} dbg_state_t;

endpackage : cycle_timing_pkg

// >>> src/op_timing_decode.sv
`timescale 1ns/1ns
module op_timing_decode
	import cycle_timing_pkg::*;
(
	input wire logic [7:0] opcode, // Opcode byte
	output logic [1:0] len, // Length in program bytes
	output logic [CNT_W-1:0] cyc_nt, // Clocks, branch not taken or no branch
	output logic [CNT_W-1:0] cyc_t, // Clocks, branch taken
	output logic is_cond, // Conditional branch
	output mem_kind_t mem_kind, // Kind of memory move
	output logic mem_write, // Memory move writes
	output logic illegal // Code point with no instruction
);

	logic [3:0] hi;
	logic [3:0] lo;
	assign hi = opcode[7:4];
	assign lo = opcode[3:0];

	// ------------------------------------------------------------
	// Length and clock table, by column then row of the opcode map
	// ------------------------------------------------------------
	always_comb begin
		len = 2'd1;
		cyc_nt = 4'h1;
		is_cond = 1'b0;
		mem_kind = MEM_NONE;
		mem_write = 1'b0;
		illegal = 1'b0;
		case (lo)
			4'h0: begin
				case (hi)
					4'h0: begin len = 2'd1; cyc_nt = 4'h1; end
					4'h1, 4'h2, 4'h3: begin len = 2'd3; cyc_nt = 4'h3; is_cond = 1'b1; end
					4'h4, 4'h5, 4'h6, 4'h7: begin len = 2'd2; cyc_nt = 4'h2; is_cond = 1'b1; end
					4'h8: begin len = 2'd2; cyc_nt = 4'h3; end
					4'h9: begin len = 2'd3; cyc_nt = 4'h3; end
					4'he: begin len = 2'd1; cyc_nt = 4'h3; mem_kind = MEM_XDPTR; end
					4'hf: begin len = 2'd1; cyc_nt = 4'h3; mem_kind = MEM_XDPTR; mem_write = 1'b1; end
					default: begin len = 2'd2; cyc_nt = 4'h2; end
				endcase
			end
			4'h1: begin len = 2'd2; cyc_nt = 4'h3; end // Absolute jump and call
			4'h2: begin
				case (hi)
					4'h0, 4'h1: begin len = 2'd3; cyc_nt = 4'h4; end
					4'h2, 4'h3: begin len = 2'd1; cyc_nt = 4'h5; end
					4'he: begin len = 2'd1; cyc_nt = 4'h3; mem_kind = MEM_XRI; end
					4'hf: begin len = 2'd1; cyc_nt = 4'h3; mem_kind = MEM_XRI; mem_write = 1'b1; end
					default: begin len = 2'd2; cyc_nt = 4'h2; end
				endcase
			end
			4'h3: begin
				case (hi)
					4'h4, 4'h5, 4'h6: begin len = 2'd3; cyc_nt = 4'h3; end
					4'h7: begin len = 2'd1; cyc_nt = 4'h3; end
					4'h8, 4'h9: begin len = 2'd1; cyc_nt = 4'h3; mem_kind = MEM_CODE; end
					4'he: begin len = 2'd1; cyc_nt = 4'h3; mem_kind = MEM_XRI; end
					4'hf: begin len = 2'd1; cyc_nt = 4'h3; mem_kind = MEM_XRI; mem_write = 1'b1; end
					default: begin len = 2'd1; cyc_nt = 4'h1; end
				endcase
			end
			4'h4: begin
				case (hi)
					4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9: begin len = 2'd2; cyc_nt = 4'h2; end
					4'h8: begin len = 2'd1; cyc_nt = 4'h8; end
					4'ha: begin len = 2'd1; cyc_nt = 4'h4; end
					4'hb: begin len = 2'd3; cyc_nt = 4'h3; is_cond = 1'b1; end
					default: begin len = 2'd1; cyc_nt = 4'h1; end
				endcase
			end
			4'h5: begin
				case (hi)
					4'h7, 4'h8: begin len = 2'd3; cyc_nt = 4'h3; end
					4'ha: begin len = 2'd1; cyc_nt = 4'h1; illegal = 1'b1; end
					4'hb, 4'hd: begin len = 2'd3; cyc_nt = 4'h3; is_cond = 1'b1; end
					default: begin len = 2'd2; cyc_nt = 4'h2; end
				endcase
			end
			4'h6, 4'h7: begin
				case (hi)
					4'h7, 4'h8, 4'ha: begin len = 2'd2; cyc_nt = 4'h2; end
					4'hb: begin len = 2'd3; cyc_nt = 4'h4; is_cond = 1'b1; end
					default: begin len = 2'd1; cyc_nt = 4'h2; end
				endcase
			end
			default: begin
				case (hi)
					4'h7, 4'h8, 4'ha: begin len = 2'd2; cyc_nt = 4'h2; end
					4'hb: begin len = 2'd3; cyc_nt = 4'h3; is_cond = 1'b1; end
					4'hd: begin len = 2'd2; cyc_nt = 4'h2; is_cond = 1'b1; end
					default: begin len = 2'd1; cyc_nt = 4'h1; end
				endcase
			end
		endcase
	end

	// Taken branches cost exactly one clock more
	assign cyc_t = is_cond ? cyc_nt + 4'h1 : cyc_nt;

endmodule : op_timing_decode

// >>> src/byte_cpu_cycle_timing.sv
`timescale 1ns/1ns
module byte_cpu_cycle_timing
	import cycle_timing_pkg::*;
#(
	parameter int NUM_BP = 4 // Hardware breakpoints
) (
	input wire logic clk, // System clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic op_valid, // Fetch offers an opcode
	input wire logic [7:0] op_byte, // Offered opcode
	input wire logic [15:0] op_pc, // Address of offered opcode
	input wire logic branch_taken, // Branch condition of offered opcode
	input wire logic [15:0] data_pointer_reg_val, // Data pointer value
	input wire logic [7:0] index_val, // Indirect index register value
	input wire logic [7:0] aux_page, // High address byte for 8-bit moves
	input wire logic [15:0] code_addr, // Computed code byte address
	input wire logic xmove_to_flash, // Ext data moves go to program flash
	input wire logic dbg_halt_req, // Debug host asks to stop
	input wire logic dbg_run_req, // Debug host asks to run
	input wire logic dbg_step_req, // Debug host asks for one instruction
	input wire logic dbg_bp_wr, // Load a breakpoint slot
	input wire logic [$clog2(NUM_BP)-1:0] dbg_bp_sel, // Breakpoint slot
	input wire logic [15:0] dbg_bp_addr, // Breakpoint address
	input wire logic dbg_bp_en, // Breakpoint slot enable
	input wire logic dbg_acc_req, // Debug memory access, while halted
	input wire logic dbg_acc_we, // Debug access writes
	input wire logic dbg_acc_flash, // Debug access targets program flash
	input wire logic [15:0] dbg_acc_addr, // Debug access address
	output logic op_ready, // Sequencer may take an opcode
	output logic instr_done, // Previous instruction finished
	output logic [1:0] instr_len, // Bytes of last taken instruction
	output logic [CNT_W-1:0] instr_cycles, // Clocks of last taken instruction
	output logic illegal_op, // Last taken opcode was undefined
	output logic mem_rd, // Memory read strobe
	output logic mem_wr, // Memory write strobe
	output logic sel_aux_ram, // Strobe targets on-chip aux RAM
	output logic sel_flash, // Strobe targets program flash
	output logic [15:0] mem_addr, // Memory address
	output logic dbg_halted, // Core is stopped for debug
	output logic dbg_bp_hit, // A breakpoint stopped the core
	output logic dbg_acc_done // Debug access issued
);

	// ------------------------------------------------------------
	// Decode of the offered opcode
	// ------------------------------------------------------------
	logic [1:0] dec_len;
	logic [CNT_W-1:0] dec_nt;
	logic [CNT_W-1:0] dec_t;
	logic dec_cond;
	mem_kind_t dec_mem;
	logic dec_we;
	logic dec_ill;

	// Binary opcode map of the classic set, 109 instructions
	op_timing_decode i_op_timing_decode (
		.opcode(op_byte),
		.len(dec_len),
		.cyc_nt(dec_nt),
		.cyc_t(dec_t),
		.is_cond(dec_cond),
		.mem_kind(dec_mem),
		.mem_write(dec_we),
		.illegal(dec_ill)
	);

	// ------------------------------------------------------------
	// Breakpoint slots
	// ------------------------------------------------------------
	logic [15:0] bp_addr_r [NUM_BP];
	logic [NUM_BP-1:0] bp_en_r;
	logic [NUM_BP-1:0] bp_match;

	// Private comparators, so user timers and RAM stay untouched
	for (genvar i = 0; i < NUM_BP; i++) begin : g_bp
		always_ff @(posedge clk) begin
			if (srst) begin
				bp_addr_r[i] <= ADDR_RST;
				bp_en_r[i] <= 1'b0;
			end else if (dbg_bp_wr && dbg_bp_sel == ($clog2(NUM_BP))'(i)) begin
				bp_addr_r[i] <= dbg_bp_addr;
				bp_en_r[i] <= dbg_bp_en;
			end
		end
		assign bp_match[i] = bp_en_r[i] && bp_addr_r[i] == op_pc;
	end

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	dbg_state_t state_r;
	dbg_state_t state_nxt;
	logic [CNT_W-1:0] rem_r;
	logic [CNT_W-1:0] rem_nxt;
	logic [CNT_W-1:0] cyc_sel;
	logic skip_bp_r;
	logic bp_stop;
	logic accept;
	logic op_ready_r;
	logic op_ready_nxt;
	logic dbg_acc;

	// A breakpoint refuses the opcode at its address; a resume steps past it
	assign bp_stop = op_valid && op_ready_r && state_r == DBG_RUN && |bp_match && !skip_bp_r;
	assign accept = op_valid && op_ready_r && !bp_stop;
	assign cyc_sel = (dec_cond && branch_taken) ? dec_t : dec_nt;
	assign dbg_acc = dbg_acc_req && state_r == DBG_HALT && rem_r == REM_RST;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			DBG_RUN: begin
				if (dbg_halt_req || bp_stop) begin
					state_nxt = DBG_HALT;
				end
			end
			DBG_HALT: begin
				if (dbg_run_req) begin
					state_nxt = DBG_RUN;
				end else if (dbg_step_req) begin
					state_nxt = DBG_STEP;
				end
			end
			DBG_STEP: begin
				if (accept || dbg_halt_req) begin
					state_nxt = DBG_HALT;
				end
			end
			default: state_nxt = DBG_HALT;
		endcase
	end

	// Remaining clocks after the current one; plain clocks, no machine cycles
	always_comb begin
		if (accept) begin
			rem_nxt = cyc_sel - 4'h1;
		end else if (rem_r != REM_RST) begin
			rem_nxt = rem_r - 4'h1;
		end else begin
			rem_nxt = REM_RST;
		end
	end

	// Ready again on the clock after the last one, so one-clock ops go back to back
	assign op_ready_nxt = rem_nxt == REM_RST && state_nxt != DBG_HALT;

	// ------------------------------------------------------------
	// Sequencer state
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			rem_r <= REM_RST;
			op_ready_r <= 1'b0;
			instr_done <= 1'b0;
		end else begin
			rem_r <= rem_nxt;
			op_ready_r <= op_ready_nxt;
			instr_done <= (accept && cyc_sel == 4'h1) || rem_r == 4'h1;
		end
	end

	// Facts of the instruction in flight
	always_ff @(posedge clk) begin
		if (srst) begin
			instr_len <= 2'd0;
			instr_cycles <= REM_RST;
			illegal_op <= 1'b0;
		end else if (accept) begin
			instr_len <= dec_len;
			instr_cycles <= cyc_sel;
			illegal_op <= dec_ill;
		end
	end

	// ------------------------------------------------------------
	// Debug control
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r <= DBG_RUN;
			skip_bp_r <= 1'b0;
			dbg_halted <= 1'b0;
			dbg_bp_hit <= 1'b0;
		end else begin
			state_r <= state_nxt;
			dbg_halted <= state_nxt == DBG_HALT;
			if (state_r == DBG_HALT && (dbg_run_req || dbg_step_req)) begin
				skip_bp_r <= 1'b1;
			end else if (accept) begin
				skip_bp_r <= 1'b0;
			end
			if (bp_stop) begin
				dbg_bp_hit <= 1'b1;
			end else if (state_nxt != DBG_HALT) begin
				dbg_bp_hit <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Memory routing; only on-chip aux RAM and flash exist
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			sel_aux_ram <= 1'b0;
			sel_flash <= 1'b0;
			mem_addr <= ADDR_RST;
			dbg_acc_done <= 1'b0;
		end else begin
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			sel_aux_ram <= 1'b0;
			sel_flash <= 1'b0;
			dbg_acc_done <= 1'b0;
			if (accept && dec_mem == MEM_CODE) begin
				mem_rd <= 1'b1;
				sel_flash <= 1'b1;
				mem_addr <= code_addr;
			end else if (accept && dec_mem != MEM_NONE) begin
				mem_rd <= !dec_we;
				mem_wr <= dec_we;
				sel_flash <= xmove_to_flash;
				sel_aux_ram <= !xmove_to_flash;
				mem_addr <= (dec_mem == MEM_XDPTR) ? data_pointer_reg_val : {aux_page, index_val};
			end else if (dbg_acc) begin
				mem_rd <= !dbg_acc_we;
				mem_wr <= dbg_acc_we;
				sel_flash <= dbg_acc_flash;
				sel_aux_ram <= !dbg_acc_flash;
				mem_addr <= dbg_acc_addr;
				dbg_acc_done <= 1'b1;
			end
		end
	end

	assign op_ready = op_ready_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	logic [CNT_W-1:0] age_r;
	logic [7:0] low_row;

	// Clocks since the last accepted opcode, saturating
	always_ff @(posedge clk) begin
		if (srst) begin
			age_r <= REM_RST;
		end else if (accept) begin
			age_r <= 4'h1;
		end else if (age_r != 4'hf) begin
			age_r <= age_r + 4'h1;
		end
	end
	assign low_row = {4'h0, op_byte[7:4]};

	property p_max_cycles;
		@(posedge clk) disable iff (srst) instr_done |-> instr_cycles <= MAX_CYCLES;
	endproperty
	a_max_cycles: assert property (p_max_cycles) else $error("instruction over eight clocks");
	property p_done_age;
		@(posedge clk) disable iff (srst) instr_done |-> age_r == instr_cycles;
	endproperty
	a_done_age: assert property (p_done_age) else $error("done not at counted clock");
	property p_rn_one;
		@(posedge clk) disable iff (srst)
			accept && op_byte[3] && low_row >= 8'h02 && low_row <= 8'h06
			|=> instr_len == 2'd1 && instr_cycles == 4'h1 && rem_r == REM_RST;
	endproperty
	a_rn_one: assert property (p_rn_one) else $error("register op not one clock");
	property p_direct_two;
		@(posedge clk) disable iff (srst)
			accept && op_byte[3:0] == 4'h5 && low_row >= 8'h02 && low_row <= 8'h06
			|=> rem_r == 4'h1 ##1 instr_done && instr_len == 2'd2;
	endproperty
	a_direct_two: assert property (p_direct_two) else $error("direct op not two clocks");
	property p_ind_two;
		@(posedge clk) disable iff (srst)
			accept && op_byte[3:1] == 3'b011 && low_row >= 8'h02 && low_row <= 8'h06
			|=> instr_len == 2'd1 && rem_r == 4'h1 ##1 instr_done;
	endproperty
	a_ind_two: assert property (p_ind_two) else $error("indirect op not two clocks");
	property p_imm_two;
		@(posedge clk) disable iff (srst)
			accept && op_byte[3:0] == 4'h4 && low_row >= 8'h02 && low_row <= 8'h06
			|=> instr_len == 2'd2 && rem_r == 4'h1;
	endproperty
	a_imm_two: assert property (p_imm_two) else $error("immediate op not two clocks");
	property p_rmw_three;
		@(posedge clk) disable iff (srst)
			accept && op_byte[3:0] == 4'h3 && low_row >= 8'h04 && low_row <= 8'h06
			|=> rem_r == 4'h2 && instr_len == 2'd3 ##1 rem_r == 4'h1 ##1 instr_done;
	endproperty
	a_rmw_three: assert property (p_rmw_three) else $error("rmw op not three clocks");
	property p_branch_gap;
		@(posedge clk) disable iff (srst)
			accept && dec_cond
			|=> instr_cycles == $past(dec_nt) + ($past(branch_taken) ? 4'h1 : 4'h0);
	endproperty
	a_branch_gap: assert property (p_branch_gap) else $error("taken branch not one longer");
	property p_jz_time;
		@(posedge clk) disable iff (srst)
			accept && op_byte == OP_JMP_ACC_ZERO
			|=> instr_cycles == ($past(branch_taken) ? 4'h3 : 4'h2);
	endproperty
	a_jz_time: assert property (p_jz_time) else $error("zero jump timing wrong");
	property p_xdptr;
		@(posedge clk) disable iff (srst)
			accept && (op_byte == OP_XMOVE_RD_DATA_POINTER_REG || op_byte == OP_XMOVE_WR_DATA_POINTER_REG)
			|=> (mem_rd || mem_wr) && mem_addr == $past(data_pointer_reg_val) && rem_r == 4'h2 ##2 instr_done;
	endproperty
	a_xdptr: assert property (p_xdptr) else $error("pointer move not three clocks");
	property p_onchip_only;
		@(posedge clk) disable iff (srst) (mem_rd || mem_wr) |-> (sel_aux_ram ^ sel_flash);
	endproperty
	a_onchip_only: assert property (p_onchip_only) else $error("move without one target");
	property p_halt_stops;
		@(posedge clk) disable iff (srst)
			state_r == DBG_RUN && dbg_halt_req |=> (!op_ready && dbg_halted) [*2];
	endproperty
	a_halt_stops: assert property (p_halt_stops) else $error("halt did not stop core");

	c_back_to_back: cover property (@(posedge clk) disable iff (srst) accept ##1 accept ##1 accept);
	c_taken_branch: cover property (@(posedge clk) disable iff (srst) accept && dec_cond && branch_taken);
	c_step: cover property (@(posedge clk) disable iff (srst) state_r == DBG_STEP && accept);
	c_bp_hit: cover property (@(posedge clk) disable iff (srst) bp_stop);

endmodule : byte_cpu_cycle_timing

// >>> test/mem_partner.sv
`timescale 1ns/1ns
// ------------------------------------------------------------
// On-chip memory side: records each strobe it is handed
// ------------------------------------------------------------
module mem_partner (
	input wire logic clk, // System clock
	input wire logic srst, // Synchronous reset, active high
	input wire logic mem_rd, // Read strobe
	input wire logic mem_wr, // Write strobe
	input wire logic sel_aux_ram, // Aux RAM selected
	input wire logic sel_flash, // Program flash selected
	input wire logic [15:0] mem_addr, // Access address
	output logic [3:0] last_kind, // Read, write, aux, flash of last strobe
	output logic [15:0] last_addr, // Address of last strobe
	output logic [7:0] n_strobes // Strobes seen since reset
);
	// Only aux RAM and flash exist on chip; a strobe with no target is kept with both select bits low
	always_ff @(posedge clk) begin
		if (srst) begin
			last_kind <= 4'h0;
			last_addr <= 16'h0000;
			n_strobes <= 8'h00;
		end else if (mem_rd || mem_wr) begin
			last_kind <= {mem_rd, mem_wr, sel_aux_ram, sel_flash};
			last_addr <= mem_addr;
			n_strobes <= n_strobes + 8'h01;
		end
	end
endmodule : mem_partner

// >>> test/tb_byte_cpu_cycle_timing.sv
`timescale 1ns/1ns
module tb_byte_cpu_cycle_timing;
	import cycle_timing_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic op_valid = 1'b0, branch_taken = 1'b0, xmove_to_flash = 1'b0;
	logic [7:0] op_byte = 8'h00, index_val = 8'h00, aux_page = 8'h00;
	logic [15:0] op_pc = 16'h0000, data_pointer_reg_val = 16'h0000, code_addr = 16'h0000;
	logic dbg_halt_req = 1'b0, dbg_run_req = 1'b0, dbg_step_req = 1'b0, dbg_bp_wr = 1'b0;
	logic [1:0] dbg_bp_sel = 2'h0;
	logic [15:0] dbg_bp_addr = 16'h0000, dbg_acc_addr = 16'h0000;
	logic dbg_bp_en = 1'b0, dbg_acc_req = 1'b0, dbg_acc_we = 1'b0, dbg_acc_flash = 1'b0;
	logic op_ready, instr_done, illegal_op, mem_rd, mem_wr, sel_aux_ram, sel_flash;
	logic dbg_halted, dbg_bp_hit, dbg_acc_done;
	logic [1:0] instr_len;
	logic [CNT_W-1:0] instr_cycles;
	logic [15:0] mem_addr, last_addr;
	logic [3:0] last_kind;
	logic [7:0] n_strobes;
	int n_errors = 0;
	int comparisons = 0;
	int n;

	// 250 MHz system clock
	always #2 clk = ~clk;

	byte_cpu_cycle_timing #(.NUM_BP(4)) i_byte_cpu_cycle_timing (.clk(clk), .srst(srst),
		.op_valid(op_valid), .op_byte(op_byte), .op_pc(op_pc), .branch_taken(branch_taken),
		.data_pointer_reg_val(data_pointer_reg_val), .index_val(index_val), .aux_page(aux_page), .code_addr(code_addr),
		.xmove_to_flash(xmove_to_flash), .dbg_halt_req(dbg_halt_req), .dbg_run_req(dbg_run_req),
		.dbg_step_req(dbg_step_req), .dbg_bp_wr(dbg_bp_wr), .dbg_bp_sel(dbg_bp_sel),
		.dbg_bp_addr(dbg_bp_addr), .dbg_bp_en(dbg_bp_en), .dbg_acc_req(dbg_acc_req),
		.dbg_acc_we(dbg_acc_we), .dbg_acc_flash(dbg_acc_flash), .dbg_acc_addr(dbg_acc_addr),
		.op_ready(op_ready), .instr_done(instr_done), .instr_len(instr_len),
		.instr_cycles(instr_cycles), .illegal_op(illegal_op), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.sel_aux_ram(sel_aux_ram), .sel_flash(sel_flash), .mem_addr(mem_addr),
		.dbg_halted(dbg_halted), .dbg_bp_hit(dbg_bp_hit), .dbg_acc_done(dbg_acc_done));

	mem_partner i_mem_partner (.clk(clk), .srst(srst), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.sel_aux_ram(sel_aux_ram), .sel_flash(sel_flash), .mem_addr(mem_addr),
		.last_kind(last_kind), .last_addr(last_addr), .n_strobes(n_strobes));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Offer one opcode at a falling edge; cycles counts clocks from take edge to done pulse
	task automatic exec(input logic [7:0] op, input logic tk, output int cycles);
		int k;
		op_byte = op;
		branch_taken = tk;
		op_valid = 1'b1;
		k = 0;
		while (op_ready !== 1'b1 && k < 20) begin
			@(negedge clk);
			k++;
		end
		@(negedge clk);
		op_valid = 1'b0;
		cycles = 1;
		while (instr_done !== 1'b1 && cycles < 12) begin
			@(negedge clk);
			cycles++;
		end
	endtask : exec

	task automatic pulse_run();
		dbg_run_req = 1'b1;
		@(negedge clk);
		dbg_run_req = 1'b0;
	endtask : pulse_run

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		repeat (16) @(negedge clk);
		check("op_ready in reset", op_ready, 16'h0);
		check("mem_addr in reset", mem_addr, ADDR_RST);
		srst = 1'b0;
		@(negedge clk);
		check("op_ready after reset", op_ready, 16'h1);
		check("halted after reset", dbg_halted, 16'h0);
	endtask : t_reset

	// One opcode of each addressing form, with its length and clock count
	task automatic t_timing();
		logic [7:0] ops [10] = '{8'h28, 8'h25, 8'h26, 8'h24, 8'h53, 8'h84, 8'ha4, 8'h93, 8'ha5, 8'he2};
		int lens [10] = '{1, 2, 1, 2, 3, 1, 1, 1, 1, 1};
		int cycs [10] = '{1, 2, 2, 2, 3, 8, 4, 3, 1, 3};
		for (int i = 0; i < 10; i++) begin
			exec(ops[i], 1'b0, n);
			check("clocks to done", n[15:0], cycs[i][15:0]);
			check("instr_len", instr_len, lens[i][15:0]);
			check("instr_cycles", instr_cycles, cycs[i][15:0]);
			check("illegal_op", illegal_op, {15'h0, ops[i] == OP_UNDEFINED});
		end
	endtask : t_timing

	task automatic t_branch();
		exec(OP_JMP_ACC_ZERO, 1'b0, n);
		check("jz not taken clocks", n[15:0], 16'h2);
		exec(OP_JMP_ACC_ZERO, 1'b1, n);
		check("jz taken clocks", n[15:0], 16'h3);
		check("jz length", instr_len, 16'h2);
	endtask : t_branch

	// Moves to aux RAM and flash, by data pointer, by page and index, and code read
	task automatic t_route();
		logic [7:0] base;
		base = n_strobes;
		data_pointer_reg_val = 16'h3a5c;
		exec(OP_XMOVE_RD_DATA_POINTER_REG, 1'b0, n);
		check("data_pointer_reg move clocks", n[15:0], 16'h3);
		check("data_pointer_reg read kind", last_kind, 16'ha);
		check("data_pointer_reg read addr", last_addr, 16'h3a5c);
		xmove_to_flash = 1'b1;
		exec(OP_XMOVE_WR_DATA_POINTER_REG, 1'b0, n);
		check("flash write kind", last_kind, 16'h5);
		xmove_to_flash = 1'b0;
		aux_page = 8'h12;
		index_val = 8'h34;
		exec(8'he3, 1'b0, n);
		check("index read addr", last_addr, 16'h1234);
		code_addr = 16'h0777;
		exec(8'h93, 1'b0, n);
		check("code read kind", last_kind, 16'h9);
		check("code read addr", last_addr, 16'h0777);
		check("strobe count", n_strobes - base, 16'h4);
	endtask : t_route

	// Two one-clock opcodes on consecutive clocks give two done pulses in a row
	task automatic t_b2b();
		op_byte = 8'h28;
		op_valid = 1'b1;
		@(negedge clk);
		op_byte = 8'h08;
		check("ready between", op_ready, 16'h1);
		check("first done", instr_done, 16'h1);
		@(negedge clk);
		op_valid = 1'b0;
		check("second done", instr_done, 16'h1);
		@(negedge clk);
		check("no third done", instr_done, 16'h0);
	endtask : t_b2b

	task automatic t_debug();
		dbg_halt_req = 1'b1;
		@(negedge clk);
		dbg_halt_req = 1'b0;
		check("halted", dbg_halted, 16'h1);
		check("ready when halted", op_ready, 16'h0);
		dbg_acc_req = 1'b1;
		dbg_acc_we = 1'b1;
		dbg_acc_flash = 1'b1;
		dbg_acc_addr = 16'h0abc;
		@(negedge clk);
		dbg_acc_req = 1'b0;
		check("debug access done", dbg_acc_done, 16'h1);
		@(negedge clk);
		check("debug write kind", last_kind, 16'h5);
		check("debug write addr", last_addr, 16'h0abc);
		dbg_step_req = 1'b1;
		@(negedge clk);
		dbg_step_req = 1'b0;
		check("step leaves halt", dbg_halted, 16'h0);
		exec(8'h28, 1'b0, n);
		check("halted after step", dbg_halted, 16'h1);
		pulse_run();
		check("running", dbg_halted, 16'h0);
	endtask : t_debug

	// Opcode at a breakpoint is refused; run resumes and lets it through once
	task automatic t_break();
		// The resume just before leaves the skip flag set; one plain take clears it
		exec(8'h00, 1'b0, n);
		dbg_bp_wr = 1'b1;
		dbg_bp_sel = 2'h1;
		dbg_bp_addr = 16'h0100;
		dbg_bp_en = 1'b1;
		@(negedge clk);
		dbg_bp_wr = 1'b0;
		op_pc = 16'h0100;
		op_byte = 8'h28;
		op_valid = 1'b1;
		@(negedge clk);
		check("bp halted", dbg_halted, 16'h1);
		check("bp hit", dbg_bp_hit, 16'h1);
		check("bp no done", instr_done, 16'h0);
		pulse_run();
		check("bp hit cleared", dbg_bp_hit, 16'h0);
		@(negedge clk);
		op_valid = 1'b0;
		check("resumed done", instr_done, 16'h1);
	endtask : t_break

	// ------------------------------------------------------------
	// Verdict, watchdog and main sequence
	// ------------------------------------------------------------
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict

	// Tests need well under a thousand clocks; twenty thousand means a hang
	initial begin
		#80000;
		n_errors++;
		print_verdict();
	end

	initial begin
		t_reset();
		t_timing();
		t_branch();
		t_route();
		t_b2b();
		t_debug();
		t_break();
		print_verdict();
	end
endmodule : tb_byte_cpu_cycle_timing
